// [asrc_pkg.sv]
/*
 * Constants, types and register map of the stereo sample rate converter.
 * Assumes one 100 MHz system clock and same-clock producers and consumers.
 */
package asrc_pkg;
    localparam int DW = 16;
    localparam int AW = 9;
    localparam int PHASE_BITS = 20;
    localparam int TAPS_BASE = 64;
    localparam int PTR_BITS = 27;
    localparam logic [7:0] MCLK_PER_OUT = 8'hff;
    localparam logic [AW-1:0] WR_LEAD = 9'h010;
    localparam logic [8:0] RATIO_ONE = 9'h040;
    localparam logic [8:0] RATIO_MAX = 9'h1c0;
    localparam logic [8:0] RATIO_HYST = 9'h002;
    localparam logic [22:0] DIV_NUM = 23'h400000;
    localparam logic [16:0] SCALE_ONE = 17'h10000;
    localparam logic [8:0] GAIN_FULL = 9'h100;
    localparam int ACC_SHIFT = 19;
    localparam int SERVO_FAST_SHIFT = 8;
    localparam int SERVO_SLOW_SHIFT = 12;
    localparam logic [28:0] SETTLE_ERR = 29'h0040000;
    localparam logic [4:0] SETTLE_RUNS = 5'h10;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h01;
    localparam logic [7:0] ADDR_ERROR = 8'h02;
    localparam logic [7:0] CLK_SEL_RESET = 8'h00;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam int MUTE_BIT = 7;
    localparam int IRQ_EN_BIT = 7;
    typedef struct packed
    {
        logic signed [DW-1:0] left;
        logic signed [DW-1:0] right;
    } asrc_pair_t;
    typedef enum logic [2:0]
    {
        CV_IDLE  = 3'b000,
        CV_FETCH = 3'b001,
        CV_MUL_L = 3'b010,
        CV_MUL_R = 3'b011,
        CV_DONE  = 3'b100
    } asrc_cv_state_t;
endpackage

// [asrc_sample_ram.sv]
/*
 * Stereo sample buffer, one word per channel per address.
 * Assumes one write and one read port on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module asrc_sample_ram
    import asrc_pkg::*;
#(
    parameter int DEPTH = 512
)
(
    input  wire logic            i_clk,
    input  wire logic            i_we,
    input  wire logic [AW-1:0]   i_waddr,
    input  wire asrc_pair_t      i_wdata,
    input  wire logic [AW-1:0]   i_raddr,
    output asrc_pair_t           o_rdata
);
    asrc_pair_t mem [DEPTH];
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk)
    begin
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

// [asrc_top.sv]
/*
 * Stereo asynchronous sample rate converter: input scaling and mute, sample
 * buffer, servo loop, rate ratio, coefficient interpolation, shared MAC.
 * Assumes input samples and master clock enables come from same-clock logic.
 */
`timescale 1ns/1ps
`default_nettype none
module asrc_top
(
    input  wire logic                 I_CLK_SYS,
    input  wire logic                 I_RST_N,
    input  wire logic [3:0]           I_MCLK_SRC_EN,
    input  wire logic                 I_IN_VALID,
    input  wire asrc_pkg::asrc_pair_t I_IN_DATA,
    input  wire logic                 I_REG_WR,
    input  wire logic [7:0]           I_REG_ADDR,
    input  wire logic [7:0]           I_REG_WDATA,
    output logic [7:0]                O_REG_RDATA,
    output asrc_pkg::asrc_pair_t      O_OUT_DATA,
    output logic                      O_OUT_VALID,
    output logic                      O_SETTLE_IRQ
);
    import asrc_pkg::*;

    // ********************
    // Reset and registers
    // ********************
    logic rst_meta_reg;
    logic rst_n;
    logic [7:0] clk_sel_reg;
    logic [7:0] delay_reg;
    logic irq_en_reg;
    logic fast_reg;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_sel_reg <= CLK_SEL_RESET;
            delay_reg <= DELAY_RESET;
            irq_en_reg <= 1'b0;
        end
        else if (I_REG_WR)
        begin
            if (I_REG_ADDR == ADDR_CLK_SEL)
                clk_sel_reg <= I_REG_WDATA;
            if (I_REG_ADDR == ADDR_DELAY)
                delay_reg <= I_REG_WDATA;
            if (I_REG_ADDR == ADDR_ERROR)
                irq_en_reg <= I_REG_WDATA[IRQ_EN_BIT];
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            O_REG_RDATA <= 8'h00;
        else if (I_REG_ADDR == ADDR_CLK_SEL)
            O_REG_RDATA <= clk_sel_reg;
        else if (I_REG_ADDR == ADDR_DELAY)
            O_REG_RDATA <= delay_reg;
        else if (I_REG_ADDR == ADDR_ERROR)
            O_REG_RDATA <= {irq_en_reg, 6'h00, fast_reg};
        else
            O_REG_RDATA <= 8'h00;
    end

    // ********************
    // Master clock and output strobe
    // ********************
    logic [7:0] div_cnt_reg;
    logic [7:0] mclk_cnt_reg;
    logic mclk_en;
    logic fs_out;
    logic [7:0] div_top;

    assign div_top = (8'h01 << clk_sel_reg[3:2]) - 8'h01;
    assign mclk_en = I_MCLK_SRC_EN[clk_sel_reg[1:0]]
                     && (div_cnt_reg >= div_top);
    assign fs_out = mclk_en && (mclk_cnt_reg == MCLK_PER_OUT);

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt_reg <= 8'h00;
        else if (I_MCLK_SRC_EN[clk_sel_reg[1:0]])
            div_cnt_reg <= mclk_en ? 8'h00 : div_cnt_reg + 8'h01;
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            mclk_cnt_reg <= 8'h00;
        else if (mclk_en)
            mclk_cnt_reg <= mclk_cnt_reg + 8'h01;
    end

    // ********************
    // Rate ratio and its reciprocal
    // ********************
    logic [5:0] win_reg;
    logic [9:0] n_in_reg;
    logic [8:0] ratio_n;
    logic [8:0] n_meas;
    logic [8:0] ratio_diff;
    logic win_end;
    logic [4:0] dv_cnt_reg;
    logic [22:0] dv_q_reg;
    logic [8:0] dv_r_reg;
    logic [9:0] dv_trial;
    logic dv_ge;
    logic dv_start;
    logic [16:0] scale_reg;

    assign win_end = fs_out && (win_reg == 6'h3f);
    assign n_meas = (n_in_reg <= {1'b0, RATIO_ONE}) ? RATIO_ONE
                  : (n_in_reg >= {1'b0, RATIO_MAX}) ? RATIO_MAX
                  : n_in_reg[8:0];
    assign ratio_diff = (n_meas > ratio_n) ? n_meas - ratio_n
                                           : ratio_n - n_meas;
    assign dv_start = win_end && (ratio_diff > RATIO_HYST);

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_reg <= 6'h00;
            n_in_reg <= 10'h000;
            ratio_n <= RATIO_ONE;
        end
        else
        begin
            if (fs_out)
                win_reg <= win_reg + 6'h01;
            if (win_end)
                n_in_reg <= {9'h000, I_IN_VALID};
            else if (I_IN_VALID && n_in_reg != 10'h3ff)
                n_in_reg <= n_in_reg + 10'h001;
            if (dv_start)
                ratio_n <= n_meas;
        end
    end

    assign dv_trial = {dv_r_reg, dv_q_reg[22]};
    assign dv_ge = dv_trial >= {1'b0, ratio_n};

    // A bit-serial divider keeps the reciprocal off the multiplier.
    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dv_cnt_reg <= 5'h00;
            dv_q_reg <= 23'h000000;
            dv_r_reg <= 9'h000;
            scale_reg <= SCALE_ONE;
        end
        else if (dv_start)
        begin
            dv_cnt_reg <= 5'h17;
            dv_q_reg <= DIV_NUM;
            dv_r_reg <= 9'h000;
        end
        else if (dv_cnt_reg != 5'h00)
        begin
            dv_cnt_reg <= dv_cnt_reg - 5'h01;
            dv_q_reg <= {dv_q_reg[21:0], dv_ge};
            dv_r_reg <= dv_ge ? 9'(dv_trial - {1'b0, ratio_n})
                              : dv_trial[8:0];
            if (dv_cnt_reg == 5'h01)
                scale_reg <= {dv_q_reg[15:0], dv_ge};
        end
    end

    // ********************
    // Input scaling and sample buffer
    // ********************
    logic [AW-1:0] in_cnt_reg;
    logic [AW-1:0] wr_addr;
    logic [8:0] gain_reg;
    logic signed [25:0] g_l;
    logic signed [25:0] g_r;
    logic signed [43:0] s_l;
    logic signed [43:0] s_r;
    asrc_pair_t wr_data;
    asrc_pair_t rd_data;
    logic [AW-1:0] rd_addr_reg;

    assign wr_addr = in_cnt_reg + WR_LEAD + {2'b00, delay_reg[6:0]};
    assign g_l = I_IN_DATA.left * $signed({1'b0, gain_reg});
    assign g_r = I_IN_DATA.right * $signed({1'b0, gain_reg});
    assign s_l = (g_l >>> 8) * $signed({1'b0, scale_reg});
    assign s_r = (g_r >>> 8) * $signed({1'b0, scale_reg});
    assign wr_data.left = s_l[31:16];
    assign wr_data.right = s_r[31:16];

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_cnt_reg <= '0;
            gain_reg <= 9'h000;
        end
        else if (I_IN_VALID)
        begin
            in_cnt_reg <= in_cnt_reg + 9'h001;
            if (delay_reg[MUTE_BIT] && gain_reg != 9'h000)
                gain_reg <= gain_reg - 9'h001;
            else if (!delay_reg[MUTE_BIT] && gain_reg != GAIN_FULL)
                gain_reg <= gain_reg + 9'h001;
        end
    end

    asrc_sample_ram #(
        .DEPTH   (512)
    ) u_ram (
        .i_clk   (I_CLK_SYS),
        .i_we    (I_IN_VALID),
        .i_waddr (wr_addr),
        .i_wdata (wr_data),
        .i_raddr (rd_addr_reg),
        .o_rdata (rd_data)
    );

    // ********************
    // Servo loop
    // ********************
    logic [28:0] rpos_reg;
    logic signed [25:0] step_reg;
    logic signed [28:0] err;
    logic [28:0] err_abs;
    logic [4:0] calm_reg;

    // Each output strobe is one coarse phase sample; the loop filter
    // averages them into a fine phase of 2^20 steps per input sample.
    assign err = $signed({in_cnt_reg, 20'h00000} - rpos_reg);
    assign err_abs = err[28] ? 29'(-err) : err;

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rpos_reg <= '0;
            step_reg <= 26'sh0100000;
            fast_reg <= 1'b1;
            calm_reg <= 5'h00;
            O_SETTLE_IRQ <= 1'b0;
        end
        else
        begin
            O_SETTLE_IRQ <= 1'b0;
            if (dv_start)
            begin
                fast_reg <= 1'b1;
                calm_reg <= 5'h00;
            end
            else if (fs_out)
            begin
                rpos_reg <= rpos_reg + 29'(step_reg);
                step_reg <= step_reg + (fast_reg
                    ? 26'(err >>> SERVO_FAST_SHIFT)
                    : 26'(err >>> SERVO_SLOW_SHIFT));
                if (err_abs >= SETTLE_ERR)
                    calm_reg <= 5'h00;
                else if (calm_reg != SETTLE_RUNS)
                    calm_reg <= calm_reg + 5'h01;
                if (fast_reg && calm_reg == SETTLE_RUNS)
                begin
                    fast_reg <= 1'b0;
                    O_SETTLE_IRQ <= irq_en_reg;
                end
            end
        end
    end

    // ********************
    // Coefficients and convolution
    // ********************
    asrc_cv_state_t cv_reg;
    logic [PTR_BITS-1:0] ptr_reg;
    logic [PTR_BITS-1:0] ptr_next;
    logic [20:0] coef_step;
    logic signed [15:0] coef_reg;
    logic signed [16:0] c0;
    logic signed [16:0] c1;
    logic signed [25:0] c_mix;
    logic signed [41:0] acc_l_reg;
    logic signed [41:0] acc_r_reg;
    logic signed [31:0] product;
    logic [9:0] tap_reg;

    function automatic logic signed [16:0] coef_at(input logic [7:0] i);
        logic [15:0] p;
        p = {8'h00, i} * {8'h00, 8'hff - i};
        return $signed({1'b0, p});
    endfunction

    function automatic logic signed [DW-1:0] sat(input logic signed [41:0] a);
        logic signed [41:0] s;
        s = a >>> ACC_SHIFT;
        if (s > 42'sh7fff)
            return 16'sh7fff;
        else if (s < -42'sh8000)
            return -16'sh8000;
        return s[15:0];
    endfunction

    // Only 256 points are kept; taps between them are interpolated.
    assign c0 = coef_at(ptr_reg[25:18]);
    assign c1 = coef_at(8'(ptr_reg[25:18] + 8'h01));
    assign c_mix = (c1 - c0) * $signed({1'b0, ptr_reg[17:10]});
    assign coef_step = {scale_reg, 4'h0};
    assign ptr_next = ptr_reg + {6'h00, coef_step};
    assign product = (cv_reg == CV_MUL_L ? rd_data.left : rd_data.right)
                     * coef_reg;

    always_ff @(posedge I_CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cv_reg <= CV_IDLE;
            ptr_reg <= '0;
            rd_addr_reg <= '0;
            coef_reg <= 16'sh0000;
            acc_l_reg <= '0;
            acc_r_reg <= '0;
            tap_reg <= 10'h000;
            O_OUT_DATA <= '0;
            O_OUT_VALID <= 1'b0;
        end
        else
        begin
            O_OUT_VALID <= 1'b0;
            case (cv_reg)
                CV_IDLE:
                begin
                    if (fs_out)
                    begin
                        rd_addr_reg <= rpos_reg[28:20];
                        ptr_reg <= {7'h00, rpos_reg[19:0]};
                        acc_l_reg <= '0;
                        acc_r_reg <= '0;
                        tap_reg <= 10'h000;
                        cv_reg <= CV_FETCH;
                    end
                end
                CV_FETCH:
                begin
                    coef_reg <= 16'(c0 + 17'(c_mix >>> 8));
                    cv_reg <= CV_MUL_L;
                end
                CV_MUL_L:
                begin
                    acc_l_reg <= acc_l_reg + 42'(product);
                    cv_reg <= CV_MUL_R;
                end
                CV_MUL_R:
                begin
                    acc_r_reg <= acc_r_reg + 42'(product);
                    rd_addr_reg <= rd_addr_reg - 9'h001;
                    ptr_reg <= {1'b0, ptr_next[25:0]};
                    tap_reg <= tap_reg + 10'h001;
                    cv_reg <= ptr_next[26] ? CV_DONE : CV_FETCH;
                end
                CV_DONE:
                begin
                    O_OUT_DATA.left <= sat(acc_l_reg);
                    O_OUT_DATA.right <= sat(acc_r_reg);
                    O_OUT_VALID <= 1'b1;
                    cv_reg <= CV_IDLE;
                end
                default:
                begin
                    cv_reg <= CV_IDLE;
                end
            endcase
        end
    end

    // ********************
    // Assertions
    // ********************
    sequence s_tap;
        cv_reg == CV_MUL_L ##1 cv_reg == CV_MUL_R;
    endsequence
    sequence s_start;
        cv_reg == CV_IDLE && fs_out;
    endsequence

    a_tap_shared_mac: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        cv_reg == CV_FETCH |=> s_tap)
        else $error("tap did not use left then right MAC slots");
    a_one_conv_start: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        s_start |=> cv_reg == CV_FETCH && rd_addr_reg == $past(rpos_reg[28:20]))
        else $error("convolution did not load servo start address");
    a_ram_addr_dec: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        cv_reg == CV_MUL_R |=> rd_addr_reg == 9'($past(rd_addr_reg) - 9'h001))
        else $error("sample address did not step down by one");
    a_ptr_rollover: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        cv_reg == CV_MUL_R && ptr_next[26] |=> cv_reg == CV_DONE ##1 O_OUT_VALID)
        else $error("pointer rollover did not end convolution");
    a_tap_count_one: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        cv_reg == CV_DONE && coef_step == 21'h100000 |-> tap_reg == 10'h040)
        else $error("unity ratio convolution not 64 taps");
    a_write_lead: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        I_IN_VALID |-> wr_addr == 9'(in_cnt_reg + 9'h010 + delay_reg[6:0]))
        else $error("write address lead wrong");
    a_ratio_floor: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        ratio_n >= RATIO_ONE && (ratio_n == RATIO_ONE || scale_reg < SCALE_ONE
        || dv_cnt_reg != 5'h00 || $past(dv_cnt_reg) != 5'h00))
        else $error("ratio below one or scale not reduced");
    a_ratio_hyst: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        $changed(ratio_n) |-> $past(win_end) && $past(ratio_diff) > 9'h002)
        else $error("ratio changed without hysteresis margin");
    a_mute_ramp: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        I_IN_VALID && delay_reg[MUTE_BIT] && gain_reg != 9'h000
        |=> gain_reg == 9'($past(gain_reg) - 9'h001))
        else $error("soft mute did not ramp gain down");
    a_settle_irq: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        $fell(fast_reg) |-> O_SETTLE_IRQ == $past(irq_en_reg))
        else $error("settle interrupt missing on slow mode");
    a_fast_on_change: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n)
        dv_start |=> fast_reg && calm_reg == 5'h00)
        else $error("rate change did not enter fast mode");
endmodule
`default_nettype wire

// [asrc_port_model.sv]
/*
 * Port-side model: four master clock source enables and the input stream.
 * Assumes the converter sits on the same clock and takes one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module asrc_port_model
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic [15:0]          i_in_period,
    input  wire asrc_pkg::asrc_pair_t i_level,
    output logic [3:0]                o_mclk_src_en,
    output logic                      o_in_valid,
    output asrc_pkg::asrc_pair_t      o_in_data
);
    import asrc_pkg::*;
    // ****************************************************
    // Sources and input samples
    // ****************************************************
    logic [3:0]  tick;
    logic [15:0] in_cnt;
    // Source k pulses once every k+1 cycles, so each source has its own rate.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tick <= 4'h0;
        else
            tick <= (tick == 4'hb) ? 4'h0 : tick + 4'h1;
    end
    always_comb
    begin
        for (int k = 0; k < 4; k++)
            o_mclk_src_en[k] = i_rst_n && ((tick % (k + 1)) == 0);
    end
    // A period of zero stops the stream, which keeps the ratio at one.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            in_cnt     <= 16'h0;
            o_in_valid <= 1'b0;
        end
        else
        begin
            o_in_valid <= (in_cnt == 16'h0) && (i_in_period != 16'h0);
            in_cnt     <= (in_cnt + 16'h1 >= i_in_period) ? 16'h0
                                                           : in_cnt + 16'h1;
        end
    end
    // Between samples the data lines carry the inverse, never the old value.
    assign o_in_data = o_in_valid ? i_level : ~i_level;
endmodule
`default_nettype wire

// [test_async_sample_rate_converter.sv]
/*
 * Self-checking bench for the converter top with the port-side model.
 * Assumes a 100 MHz clock and registers reached by the plain write strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module test_async_sample_rate_converter;
    import asrc_pkg::*;
    // ****************************************************
    // Clock, reset, instances
    // ****************************************************
    logic        I_CLK_SYS = 1'b0;
    logic        I_RST_N   = 1'b0;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [15:0] in_period = 16'h0100;
    asrc_pair_t  level     = {16'h2000, 16'he000};
    logic [7:0]  rdata;
    logic [3:0]  mclk_en;
    logic        in_valid;
    logic        out_valid;
    logic        irq;
    asrc_pair_t  in_data;
    asrc_pair_t  out_data;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    always #5 I_CLK_SYS = ~I_CLK_SYS;
    asrc_top DUT (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
        .I_MCLK_SRC_EN(mclk_en), .I_IN_VALID(in_valid), .I_IN_DATA(in_data),
        .I_REG_WR(reg_wr), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
        .O_REG_RDATA(rdata), .O_OUT_DATA(out_data), .O_OUT_VALID(out_valid),
        .O_SETTLE_IRQ(irq));
    asrc_port_model partner (.i_clk(I_CLK_SYS), .i_rst_n(I_RST_N),
        .i_in_period(in_period), .i_level(level), .o_mclk_src_en(mclk_en),
        .o_in_valid(in_valid), .o_in_data(in_data));
    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // A hung wait counts as a mismatch rather than stalling the run.
    always @(posedge I_CLK_SYS)
    begin
        cycles++;
        if (cycles == 99000)
        begin
            miscompares++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CLK_SYS);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge I_CLK_SYS);
        #1;
        reg_wr = 1'b0;
    endtask
    task automatic reg_expect(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CLK_SYS);
        #1;
        reg_addr = a;
        @(posedge I_CLK_SYS);
        #1;
        check(rdata, d, "register read");
    endtask
    task automatic wait_out(output int t);
        int k;
        k = 0;
        do
        begin
            @(posedge I_CLK_SYS);
            #1;
            k++;
        end while (out_valid !== 1'b1 && k < 4000);
        check(k < 4000, 1, "output pair arrives");
        t = cycles;
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_regs();
        reg_expect(ADDR_CLK_SEL, 8'h00);
        reg_expect(ADDR_DELAY, 8'h00);
        reg_expect(ADDR_ERROR, 8'h01);
        reg_expect(8'h03, 8'h00);
        reg_write(ADDR_DELAY, 8'h85);
        reg_expect(ADDR_DELAY, 8'h85);
        reg_write(ADDR_ERROR, 8'hfe);
        reg_expect(ADDR_ERROR, 8'h81);
        reg_write(ADDR_CLK_SEL, 8'hf0);
        reg_expect(ADDR_CLK_SEL, 8'hf0);
        reg_write(ADDR_CLK_SEL, 8'h00);
        reg_write(ADDR_DELAY, 8'h80);
    endtask
    // Muted by t_regs before the first input sample, the input gain never rises, so output stays zero.
    task automatic t_settle();
        int  k;
        logic seen;
        k    = 0;
        seen = 1'b0;
        while (k < 40000 && !seen)
        begin
            @(posedge I_CLK_SYS);
            #1;
            k++;
            seen = (irq === 1'b1);
            if (out_valid === 1'b1)
                check(out_data, 32'h0, "muted output");
        end
        check(seen, 1, "settle interrupt");
        reg_expect(ADDR_ERROR, 8'h80);
    endtask
    task automatic t_unmute();
        int t;
        reg_write(ADDR_DELAY, 8'h00);
        repeat (120) wait_out(t);
        check(out_data.left[15], 0, "left sign");
        check(out_data.left != 16'h0, 1, "left nonzero");
        check(out_data.right[15], 1, "right sign");
    endtask
    task automatic t_period(input logic [7:0] sel, input int exp);
        int t1;
        int t2;
        reg_write(ADDR_CLK_SEL, sel);
        wait_out(t1);
        wait_out(t1);
        wait_out(t1);
        wait_out(t2);
        check(t2 - t1, exp, "output period");
    endtask
    initial
    begin
        repeat (10) @(posedge I_CLK_SYS);
        #1;
        I_RST_N = 1'b1;
        repeat (4) @(posedge I_CLK_SYS);
        t_regs();
        t_settle();
        t_unmute();
        in_period = 16'h0000;
        t_period(8'h00, 256);
        t_period(8'h04, 512);
        t_period(8'h01, 512);
        t_period(8'h03, 1024);
        t_period(8'h0a, 3072);
        conclude();
    end
endmodule
`default_nettype wire
